// >>> fbc_flash_array.sv
// Behavioural flash array that answers the controller's array port.
`timescale 1ns/1ns
module fbc_flash_array (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Security byte value loaded while reset is low
  input wire logic [7:0] sec_init,
  // Array port
  input wire logic [14:0] arr_addr,
  input wire logic [7:0] arr_wdata,
  input wire logic arr_program,
  input wire logic arr_erase,
  input wire fbc_pkg::fbc_size_e arr_erase_size,
  output logic [7:0] arr_rdata
);
  logic [7:0] mem [0:32767];
  logic busy_q;
  int span;
  int base;

  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
  end

  assign arr_rdata = mem[arr_addr];

  // ------------------------------------------------------------------
  // Program and erase act once, at the first cycle of an operation.
  // ------------------------------------------------------------------
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mem[15'h7FFF] = sec_init;
      busy_q = 1'b0;
    end else begin
      if ((arr_program || arr_erase) && !busy_q) begin
        if (arr_program) begin
          mem[arr_addr] = mem[arr_addr] & arr_wdata;
        end else begin
          case (arr_erase_size)
            fbc_pkg::SZ_PAGE: span = 32;
            fbc_pkg::SZ_BLOCK: span = 256;
            default: span = 32768;
          endcase
          base = int'(arr_addr) & ~(span - 1);
          for (int j = 0; j < span; j++) mem[base + j] = 8'hFF;
        end
      end
      busy_q = arr_program || arr_erase;
    end
  end
endmodule : fbc_flash_array

// >>> fbc_flash_ctrl.sv
// Program-memory flash controller: boot map, control register, erase/write sequencer.
`timescale 1ns/1ns
module fbc_flash_ctrl #(
  parameter logic [12:0] WRITE_TICKS = fbc_pkg::WRITE_TICKS,
  parameter logic [12:0] ERASE_TICKS = fbc_pkg::ERASE_TICKS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Strap pins
  input wire logic external_access_n,
  input wire logic program_store_en_n,
  input wire logic ale,
  // Special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Instruction fetch
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_is_return,
  output logic fetch_boot,
  output logic fetch_internal,
  output logic fetch_external,
  output logic fetch_stall,
  output logic [fbc_pkg::BOOT_AW-1:0] boot_rom_addr,
  output logic core_run,
  // Boot routine parameters and results
  input wire logic [15:0] data_pointer,
  input wire logic [7:0] accumulator,
  output logic result_valid,
  output logic [7:0] result_acc,
  output logic [15:0] result_ptr,
  // Flash array
  input wire logic [7:0] arr_rdata,
  output logic [fbc_pkg::ARR_AW-1:0] arr_addr,
  output logic [7:0] arr_wdata,
  output logic arr_program,
  output logic arr_erase,
  output fbc_pkg::fbc_size_e arr_erase_size,
  output logic high_voltage_active,
  output logic security_active
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  fbc_pkg::fbc_state_e st_q, st_d;
  fbc_pkg::fbc_size_e size_q, size_d;
  logic [1:0] init_q, init_d;
  logic sel_hi_q, sel_hi_d;
  logic sel_lo_q, sel_lo_d;
  logic [3:0] fc_q, fc_d;
  logic sec_q, sec_d;
  logic int_en_q, int_en_d;
  logic [3:0] div_q, div_d;
  logic [12:0] cnt_q, cnt_d;
  logic [15:0] op_ptr_q, op_ptr_d;
  logic [7:0] op_data_q, op_data_d;
  logic [7:0] res_acc_q, res_acc_d;
  logic [15:0] res_ptr_q, res_ptr_d;
  logic res_valid_q, res_valid_d;
  logic prev_boot_q, prev_boot_d;
  logic exec_int_q, exec_int_d;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] pins_s;
  logic busy;
  logic tick;
  logic above_base;
  logic reg_hit_wr;
  logic [12:0] target;
  logic [15:0] erase_base;

  fbc_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clock(clock),
    .arst_n(arst_n),
    .d({external_access_n, program_store_en_n, ale}),
    .q(pins_s)
  );

  // ---------------------------------------------------------------------------
  // Program space map
  // ---------------------------------------------------------------------------
  always_comb begin
    above_base = fetch_addr >= fbc_pkg::BOOT_BASE;
    // Select 1,1 covers all; a single select bit covers only the top 1K.
    fetch_boot = (sel_hi_q & sel_lo_q) | ((sel_hi_q ^ sel_lo_q) & above_base);
    // Internal flash answers below 32K only when the strap enabled it.
    fetch_internal = !fetch_boot && int_en_q && (fetch_addr < fbc_pkg::INTERNAL_LIMIT);
    fetch_external = !fetch_boot && !fetch_internal;
  end

  assign busy = st_q == fbc_pkg::ST_BUSY;
  assign fetch_stall = fetch_valid && fetch_internal && busy;
  assign boot_rom_addr = fetch_addr[fbc_pkg::BOOT_AW-1:0];
  assign core_run = st_q != fbc_pkg::ST_INIT;
  assign tick = busy && (div_q == fbc_pkg::TICK_LAST);
  assign reg_hit_wr = sfr_wr && (sfr_addr == fbc_pkg::FLASH_CONTROL_ADDR);
  assign target = (size_q == fbc_pkg::SZ_BYTE) ? WRITE_TICKS : ERASE_TICKS;

  // The array always sees the aligned base of the region being erased.
  always_comb begin
    case (size_q)
      fbc_pkg::SZ_PAGE: erase_base = op_ptr_q & fbc_pkg::PAGE_MASK;
      fbc_pkg::SZ_BLOCK: erase_base = op_ptr_q & fbc_pkg::BLOCK_MASK;
      fbc_pkg::SZ_FULL: erase_base = op_ptr_q & fbc_pkg::FULL_MASK;
      default: erase_base = op_ptr_q;
    endcase
  end

  always_comb begin
    if (st_q == fbc_pkg::ST_INIT) begin
      arr_addr = fbc_pkg::SECURITY_ADDR;
    end else if (busy) begin
      arr_addr = erase_base[fbc_pkg::ARR_AW-1:0];
    end else begin
      arr_addr = data_pointer[fbc_pkg::ARR_AW-1:0];
    end
  end

  assign arr_program = busy && (size_q == fbc_pkg::SZ_BYTE);
  assign arr_erase = busy && (size_q != fbc_pkg::SZ_BYTE);
  assign arr_wdata = arr_erase ? fbc_pkg::ERASED_BYTE : op_data_q;
  assign arr_erase_size = size_q;
  assign high_voltage_active = busy;
  assign security_active = sec_q;
  assign result_valid = res_valid_q;
  assign result_acc = res_acc_q;
  assign result_ptr = res_ptr_q;
  assign sfr_rdata = rdata_q;

  // ---------------------------------------------------------------------------
  // Sequencer and control register
  // ---------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    size_d = size_q;
    init_d = init_q;
    sel_hi_d = sel_hi_q;
    sel_lo_d = sel_lo_q;
    fc_d = fc_q;
    sec_d = sec_q;
    int_en_d = int_en_q;
    div_d = div_q;
    cnt_d = cnt_q;
    op_ptr_d = op_ptr_q;
    op_data_d = op_data_q;
    res_acc_d = res_acc_q;
    res_ptr_d = res_ptr_q;
    res_valid_d = 1'b0;
    prev_boot_d = prev_boot_q;
    exec_int_d = exec_int_q;
    rdata_d = rdata_q;
    case (st_q)
      fbc_pkg::ST_INIT: begin
        init_d = init_q + 2'h1;
        if (init_q == fbc_pkg::INIT_LAST) begin
          st_d = fbc_pkg::ST_IDLE;
          int_en_d = pins_s[2];
          // Boot strap: program-store and external-access low, ALE high.
          sel_hi_d = !pins_s[2] && !pins_s[1] && pins_s[0];
          sel_lo_d = !pins_s[2] && !pins_s[1] && pins_s[0];
          // Only an unprogrammed or cleared byte turns protection off.
          sec_d = (arr_rdata != fbc_pkg::SEC_OFF_ZERO) && (arr_rdata != fbc_pkg::ERASED_BYTE);
        end
      end
      fbc_pkg::ST_IDLE: begin
        if (fetch_valid && fetch_boot) begin
          op_ptr_d = data_pointer;
          op_data_d = accumulator;
          cnt_d = '0;
          div_d = '0;
          case (fetch_addr)
            fbc_pkg::ENTRY_READ: begin
              if (fc_q == fbc_pkg::FC_BYTE) begin
                res_acc_d = arr_rdata;
                res_ptr_d = data_pointer;
                res_valid_d = 1'b1;
              end
            end
            fbc_pkg::ENTRY_WRITE: begin
              if (fc_q == fbc_pkg::FC_BYTE) begin
                size_d = fbc_pkg::SZ_BYTE;
                st_d = fbc_pkg::ST_BUSY;
              end
            end
            fbc_pkg::ENTRY_PAGE: begin
              if (fc_q == fbc_pkg::FC_PAGE) begin
                size_d = fbc_pkg::SZ_PAGE;
                st_d = fbc_pkg::ST_BUSY;
              end
            end
            fbc_pkg::ENTRY_BLOCK: begin
              if (fc_q == fbc_pkg::FC_BLOCK) begin
                size_d = fbc_pkg::SZ_BLOCK;
                st_d = fbc_pkg::ST_BUSY;
              end
            end
            fbc_pkg::ENTRY_FULL: begin
              if (fc_q == fbc_pkg::FC_FULL) begin
                size_d = fbc_pkg::SZ_FULL;
                st_d = fbc_pkg::ST_BUSY;
              end
            end
            default: begin
            end
          endcase
        end
      end
      fbc_pkg::ST_BUSY: begin
        div_d = tick ? '0 : div_q + 4'h1;
        if (tick) begin
          cnt_d = cnt_q + 13'h1;
          if (cnt_q == target - 13'h1) begin
            st_d = fbc_pkg::ST_IDLE;
            res_valid_d = 1'b1;
            case (size_q)
              fbc_pkg::SZ_PAGE: begin
                res_acc_d = fbc_pkg::ACC_PAGE;
                res_ptr_d = op_ptr_q & fbc_pkg::PAGE_MASK;
              end
              fbc_pkg::SZ_BLOCK: begin
                res_acc_d = fbc_pkg::ACC_BLOCK;
                res_ptr_d = {op_ptr_q[15:8], fbc_pkg::BLOCK_PTR_LOW};
              end
              fbc_pkg::SZ_FULL: begin
                res_acc_d = fbc_pkg::ACC_FULL;
                res_ptr_d = fbc_pkg::FULL_PTR_OUT;
                sec_d = 1'b0;
              end
              default: begin
                res_acc_d = arr_rdata;
                res_ptr_d = op_ptr_q;
              end
            endcase
          end
        end
      end
      default: st_d = fbc_pkg::ST_INIT;
    endcase
    if (core_run && reg_hit_wr) begin
      sel_hi_d = sfr_wdata[fbc_pkg::SEL_HI_BIT];
      sel_lo_d = sfr_wdata[fbc_pkg::SEL_LO_BIT];
      if (!sec_q || exec_int_q || sfr_wdata[fbc_pkg::FC_MSB:0] == fbc_pkg::FC_FULL) begin
        fc_d = sfr_wdata[fbc_pkg::FC_MSB:0];
      end
    end
    // A stalled fetch has not executed, so it leaves the fetch history alone.
    if (core_run && fetch_valid && !fetch_stall) begin
      prev_boot_d = fetch_boot;
      exec_int_d = fetch_internal;
      // Hardware clears win over a software write in the same cycle.
      if (sel_hi_q && !sel_lo_q && !fetch_boot) begin
        sel_hi_d = 1'b0;
      end
      if (fetch_is_return && prev_boot_q && !fetch_boot) begin
        sel_hi_d = 1'b0;
        sel_lo_d = 1'b0;
      end
    end
    if (sfr_rd) begin
      rdata_d = '0;
      if (sfr_addr == fbc_pkg::FLASH_CONTROL_ADDR) begin
        rdata_d[fbc_pkg::SEL_HI_BIT] = sel_hi_q;
        rdata_d[fbc_pkg::SEL_LO_BIT] = sel_lo_q;
        rdata_d[fbc_pkg::HV_BIT] = busy;
        rdata_d[fbc_pkg::FC_MSB:0] = fc_q;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= fbc_pkg::ST_INIT;
      size_q <= fbc_pkg::SZ_BYTE;
      init_q <= '0;
      sel_hi_q <= 1'b0;
      sel_lo_q <= 1'b0;
      fc_q <= fbc_pkg::FC_RESET;
      sec_q <= 1'b0;
      int_en_q <= 1'b0;
      div_q <= '0;
      cnt_q <= '0;
      op_ptr_q <= '0;
      op_data_q <= '0;
      res_acc_q <= '0;
      res_ptr_q <= '0;
      res_valid_q <= 1'b0;
      prev_boot_q <= 1'b0;
      exec_int_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      st_q <= st_d;
      size_q <= size_d;
      init_q <= init_d;
      sel_hi_q <= sel_hi_d;
      sel_lo_q <= sel_lo_d;
      fc_q <= fc_d;
      sec_q <= sec_d;
      int_en_q <= int_en_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      op_ptr_q <= op_ptr_d;
      op_data_q <= op_data_d;
      res_acc_q <= res_acc_d;
      res_ptr_q <= res_ptr_d;
      res_valid_q <= res_valid_d;
      prev_boot_q <= prev_boot_d;
      exec_int_q <= exec_int_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  localparam int ERASE_MAX = 50000;
  localparam int WRITE_MAX = 25000;
  logic [15:0] run_len_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      run_len_q <= '0;
    end else begin
      run_len_q <= busy ? run_len_q + 16'h1 : '0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_launch;
    (st_q == fbc_pkg::ST_IDLE) ##1 busy;
  endsequence
  sequence s_finish_full;
    arr_erase && (size_q == fbc_pkg::SZ_FULL) ##1 !busy;
  endsequence

  property p_launch_hv;
    s_launch |-> high_voltage_active && (arr_program || arr_erase) [*2];
  endproperty
  a_launch_hv: assert property (p_launch_hv) else $error("high voltage missing on launch");
  property p_erase_len;
    arr_erase |-> run_len_q < 16'(ERASE_MAX);
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase too long");
  property p_write_len;
    arr_program |-> run_len_q < 16'(WRITE_MAX);
  endproperty
  a_write_len: assert property (p_write_len) else $error("write too long");
  property p_full_out;
    s_finish_full |-> result_valid && result_ptr == fbc_pkg::FULL_PTR_OUT && !security_active;
  endproperty
  a_full_out: assert property (p_full_out) else $error("full erase results wrong");
  property p_ret_clear;
    core_run && fetch_valid && !fetch_stall && fetch_is_return && prev_boot_q && !fetch_boot
      |=> !sel_hi_q && !sel_lo_q;
  endproperty
  a_ret_clear: assert property (p_ret_clear) else $error("select bits not cleared on return");
  property p_user_clear;
    core_run && fetch_valid && !fetch_stall && sel_hi_q && !sel_lo_q && !fetch_boot |=> !sel_hi_q;
  endproperty
  a_user_clear: assert property (p_user_clear) else $error("upper select not cleared");
  property p_map;
    sel_lo_q && !sel_hi_q |-> fetch_boot == above_base;
  endproperty
  a_map: assert property (p_map) else $error("split map wrong");
  property p_stall;
    busy && fetch_valid && !fetch_boot && int_en_q && (fetch_addr < fbc_pkg::INTERNAL_LIMIT)
      |-> fetch_stall;
  endproperty
  a_stall: assert property (p_stall) else $error("flash fetch not stalled");
  property p_secure_fc;
    reg_hit_wr && sec_q && !exec_int_q && sfr_wdata[fbc_pkg::FC_MSB:0] != fbc_pkg::FC_FULL
      |=> $stable(fc_q);
  endproperty
  a_secure_fc: assert property (p_secure_fc) else $error("protected code changed");
  property p_reserved;
    sfr_rdata[fbc_pkg::RSVD_BIT] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

endmodule : fbc_flash_ctrl

// >>> fbc_flash_ctrl_bench.sv
// Self-checking bench for the program-memory flash controller.
`timescale 1ns/1ns
module fbc_flash_ctrl_bench;
  localparam int WR_CYC = 30;
  localparam int ER_CYC = 50;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic external_access_n = 1'b1, program_store_en_n = 1'b1, ale = 1'b1;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, fetch_valid = 1'b0, fetch_is_return = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, accumulator = 8'h00, sec_init = 8'hFF;
  logic [15:0] fetch_addr = 16'h0000, data_pointer = 16'h0000;
  logic [7:0] sfr_rdata, result_acc, arr_rdata, arr_wdata, v;
  logic fetch_boot, fetch_internal, fetch_external, fetch_stall, core_run, result_valid;
  logic arr_program, arr_erase, high_voltage_active, security_active;
  logic [9:0] boot_rom_addr;
  logic [15:0] result_ptr, dp, base;
  logic [14:0] arr_addr;
  fbc_pkg::fbc_size_e arr_erase_size;
  int err_total = 0, n_tests = 0, seed = 19672, n, sz;
  logic [3:0] fc_t [3] = '{4'hC, 4'h3, 4'hA};
  logic [15:0] ent_t [3] = '{16'hFFAA, 16'hFFA5, 16'hFFA0};
  logic [7:0] acc_t [3] = '{8'h08, 8'h02, 8'h0A};

  always #50 clock = ~clock;

  fbc_flash_ctrl #(.WRITE_TICKS(13'h0003), .ERASE_TICKS(13'h0005)) i_fbc_flash_ctrl (
    .clock, .arst_n, .external_access_n, .program_store_en_n, .ale, .sfr_addr, .sfr_wr,
    .sfr_rd, .sfr_wdata, .sfr_rdata, .fetch_valid, .fetch_addr, .fetch_is_return,
    .fetch_boot, .fetch_internal, .fetch_external, .fetch_stall, .boot_rom_addr,
    .core_run, .data_pointer, .accumulator, .result_valid, .result_acc, .result_ptr,
    .arr_rdata, .arr_addr, .arr_wdata, .arr_program, .arr_erase, .arr_erase_size,
    .high_voltage_active, .security_active);
  fbc_flash_array i_fbc_flash_array (.clock, .arst_n, .sec_init, .arr_addr, .arr_wdata,
    .arr_program, .arr_erase, .arr_erase_size, .arr_rdata);

  function automatic logic [15:0] exp_ptr(input int k, input logic [15:0] d);
    if (k == 0) return {d[15:5], 5'h00};
    if (k == 1) return {d[15:8], 8'h08};
    return 16'h0018;
  endfunction : exp_ptr

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic rst(input logic e, input logic p, input logic [7:0] s);
    arst_n = 1'b0;
    external_access_n = e;
    program_store_en_n = p;
    sec_init = s;
    repeat (10) @(posedge clock);
    #10;
    chk(core_run, 1'b0);
    chk(arr_addr, 15'h7FFF);
    arst_n = 1'b1;
    repeat (5) @(posedge clock);
    #10;
    chk(core_run, 1'b1);
  endtask : rst

  task automatic wr(input logic [7:0] d);
    sfr_addr = 8'hFB;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clock);
    #10 sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(output logic [7:0] d);
    sfr_addr = 8'hFB;
    sfr_rd = 1'b1;
    @(posedge clock);
    #10 sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : rd

  task automatic fetch(input logic [15:0] a, input logic r);
    fetch_addr = a;
    fetch_is_return = r;
    fetch_valid = 1'b1;
    @(posedge clock);
    #10 fetch_valid = 1'b0;
    fetch_is_return = 1'b0;
  endtask : fetch

  task automatic op(input logic [3:0] fc, input logic [15:0] ent, d, input logic [7:0] a);
    logic [7:0] r;
    wr({4'h4, fc});
    data_pointer = d;
    accumulator = a;
    fetch(ent, 1'b0);
    n = 0;
    if (ent != 16'hFFBA) begin
      chk(high_voltage_active, 1'b1);
      rd(r);
      chk(r[5], 1'b1);
      fetch_addr = 16'h0100;
      fetch_valid = 1'b1;
      #1 chk(fetch_stall, 1'b1);
      @(posedge clock);
      #10 fetch_valid = 1'b0;
      n = 2;
    end
    while (result_valid !== 1'b1 && n < 300) begin
      @(posedge clock);
      #10 n++;
    end
    chk(result_valid, 1'b1);
    fetch(16'h0100, 1'b1);
  endtask : op

  initial begin
    #2000000;
    err_total++;
    end_sim();
  end

  initial begin
    rst(1'b1, 1'b1, 8'hFF);
    rd(v);
    chk(v, 8'h00);
    chk(security_active, 1'b0);
    fetch_addr = 16'h0000;
    #1 chk({fetch_boot, fetch_internal}, 2'b01);
    fetch_addr = 16'hFFAD;
    #1 chk({fetch_boot, fetch_external}, 2'b01);
    wr(8'h75);
    rd(v);
    chk(v, 8'h45);
    fetch_addr = 16'hFFAD;
    #1 chk(fetch_boot, 1'b1);
    fetch_addr = 16'hFBFF;
    #1 chk({fetch_boot, fetch_external}, 2'b01);
    dp = 16'($random(seed)) & 16'h7FFE;
    v = 8'($random(seed));
    op(4'h5, 16'hFFAD, dp, v);
    chk(16'(n), 16'(WR_CYC));
    chk(result_acc, v);
    chk(result_ptr, dp);
    rd(v);
    chk(v, 8'h05);
    for (int k = 0; k < 3; k++) begin
      sz = (k == 0) ? 32 : (k == 1) ? 256 : 32768;
      base = (k == 2) ? 16'h0000 : 16'($random(seed)) & 16'h3F00;
      op(4'h5, 16'hFFAD, base + 16'(sz - 1), 8'h00);
      if (k < 2) op(4'h5, 16'hFFAD, base + 16'(sz), 8'h00);
      dp = base | (16'($random(seed)) & 16'(sz - 1));
      op(fc_t[k], ent_t[k], dp, 8'h5A);
      chk(16'(n), 16'(ER_CYC));
      chk(result_acc, acc_t[k]);
      chk(result_ptr, exp_ptr(k, dp));
      rd(v);
      chk(v, {4'h0, fc_t[k]});
      op(4'h5, 16'hFFBA, base + 16'(sz - 1), 8'h00);
      chk(result_acc, 8'hFF);
      if (k < 2) op(4'h5, 16'hFFBA, base + 16'(sz), 8'h00);
      if (k < 2) chk(result_acc, 8'h00);
    end
    rst(1'b1, 1'b1, 8'h50);
    chk(security_active, 1'b1);
    fetch(16'h8100, 1'b0);
    wr(8'h45);
    rd(v);
    chk(v, 8'h40);
    wr(8'h4A);
    rd(v);
    chk(v, 8'h4A);
    fetch(16'h0100, 1'b0);
    wr(8'h45);
    rd(v);
    chk(v, 8'h45);
    op(4'hA, 16'hFFA0, 16'h1234, 8'h00);
    chk(security_active, 1'b0);
    rst(1'b0, 1'b0, 8'hFF);
    rd(v);
    chk(v, 8'hC0);
    fetch_addr = 16'h0000;
    #1 chk({fetch_boot, boot_rom_addr}, {1'b1, 10'h000});
    fetch_addr = 16'h7000;
    #1 chk(fetch_boot, 1'b1);
    wr(8'h80);
    fetch(16'hFC00, 1'b0);
    chk(fetch_boot, 1'b1);
    fetch_addr = 16'h1000;
    #1 chk({fetch_boot, fetch_external}, 2'b01);
    fetch(16'h1000, 1'b0);
    rd(v);
    chk(v, 8'h00);
    end_sim();
  end
endmodule : fbc_flash_ctrl_bench

// >>> fbc_pkg.sv
// Constants, encodings and timing for the program-memory flash controller.
package fbc_pkg;

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FLASH_CONTROL_ADDR = 8'hFB;
  localparam int SEL_HI_BIT = 7;
  localparam int SEL_LO_BIT = 6;
  localparam int HV_BIT = 5;
  localparam int RSVD_BIT = 4;
  localparam int FC_MSB = 3;
  localparam logic [3:0] FC_RESET = 4'h0;
  localparam logic [3:0] FC_BYTE = 4'h5;
  localparam logic [3:0] FC_PAGE = 4'hC;
  localparam logic [3:0] FC_BLOCK = 4'h3;
  localparam logic [3:0] FC_FULL = 4'hA;

  // ---------------------------------------------------------------------------
  // Program space map
  // ---------------------------------------------------------------------------
  localparam logic [15:0] BOOT_BASE = 16'hFC00;
  localparam logic [15:0] INTERNAL_LIMIT = 16'h8000;
  localparam int BOOT_ROM_BYTES = 1024;
  localparam int BOOT_AW = $clog2(BOOT_ROM_BYTES);
  localparam logic [15:0] ENTRY_READ = 16'hFFBA;
  localparam logic [15:0] ENTRY_WRITE = 16'hFFAD;
  localparam logic [15:0] ENTRY_PAGE = 16'hFFAA;
  localparam logic [15:0] ENTRY_BLOCK = 16'hFFA5;
  localparam logic [15:0] ENTRY_FULL = 16'hFFA0;

  // ---------------------------------------------------------------------------
  // Flash array
  // ---------------------------------------------------------------------------
  localparam int ARR_AW = 15;
  localparam int PAGE_BYTES = 32;
  localparam int BLOCK_BYTES = 256;
  localparam int FULL_BYTES = 32768;
  localparam logic [15:0] PAGE_MASK = 16'(~(PAGE_BYTES - 1));
  localparam logic [15:0] BLOCK_MASK = 16'(~(BLOCK_BYTES - 1));
  localparam logic [15:0] FULL_MASK = 16'(~(FULL_BYTES - 1));
  localparam logic [14:0] SECURITY_ADDR = 15'h7FFF;
  localparam logic [7:0] SEC_OFF_ZERO = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ---------------------------------------------------------------------------
  // Values returned by the boot routines
  // ---------------------------------------------------------------------------
  localparam logic [7:0] BLOCK_PTR_LOW = 8'h08;
  localparam logic [15:0] FULL_PTR_OUT = 16'h0018;
  localparam logic [7:0] ACC_PAGE = 8'h08;
  localparam logic [7:0] ACC_BLOCK = 8'h02;
  localparam logic [7:0] ACC_FULL = 8'h0A;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [3:0] TICK_LAST = 4'(TICK_CYCLES - 1);
  localparam int WRITE_TIME_NS = 2500000;
  localparam int ERASE_TIME_NS = 5000000;
  localparam logic [12:0] WRITE_TICKS = 13'(WRITE_TIME_NS / TICK_NS);
  localparam logic [12:0] ERASE_TICKS = 13'(ERASE_TIME_NS / TICK_NS);
  localparam logic [1:0] INIT_LAST = 2'h3;

  typedef enum logic [1:0] {SZ_BYTE, SZ_PAGE, SZ_BLOCK, SZ_FULL} fbc_size_e;
  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_BUSY} fbc_state_e;

endpackage : fbc_pkg

// >>> fbc_sync.sv
// Two-stage synchroniser for asynchronous pin levels.
`timescale 1ns/1ns
module fbc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = d;
    sync_d = meta_q;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q = sync_q;

endmodule : fbc_sync
